// >>> hw/mafe_device.sv
// front end end of the serial port: command bytes, result frames, beeper, conversion timing
`include "mafe_map.svh"
module mafe_device import mafe_pkg::*; #(
  parameter int MS_CYCLES = `MAFE_MS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  mafe_link_if.device link,
  input wire logic fast_done,
  input wire logic slow_done,
  input wire logic slow_result_negative,
  input wire logic fast_result_negative,
  input wire logic [1:0] battery_level_flags,
  input wire logic divider_flag_lo,
  input wire logic divider_flag_hi,
  input wire logic alarm_flag,
  input wire logic high_freq_flag,
  input wire logic low_freq_flag,
  input wire logic low_duty_flag,
  input wire logic cycle_done_flag,
  input wire logic [18:0] slow_result,
  input wire logic [9:0] fast_result,
  input wire logic [18:0] aux_result,
  input wire logic [18:0] freq_result,
  output logic [7:0] cmd_function_range,
  output logic [7:0] cmd_tone_rate_freq,
  output logic [7:0] cmd_ac_filter_opts,
  output logic [7:0] cmd_inrush_amp_adapter,
  output logic beeper_on,
  output logic beeper_drive_out,
  output logic fast_tick,
  output logic slow_tick
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // results go out lowest bit first inside msb-first bytes
  function automatic logic [18:0] bit_rev(input logic [18:0] v);
    logic [18:0] r;
    r = '0;
    for (int i = 0; i < 19; i++) begin
      r[i] = v[18 - i];
    end
    return r;
  endfunction : bit_rev

  function automatic logic [16:0] tone_half(input logic [2:0] code);
    int unsigned t;
    t = `MAFE_TONE_0;
    case (code)
      3'h0: t = `MAFE_TONE_0;
      3'h1: t = `MAFE_TONE_1;
      3'h2: t = `MAFE_TONE_2;
      3'h3: t = `MAFE_TONE_3;
      3'h4: t = `MAFE_TONE_4;
      3'h5: t = `MAFE_TONE_5;
      3'h6: t = `MAFE_TONE_6;
      default: t = `MAFE_TONE_7;
    endcase
    return 17'((`MAFE_PCLK_HZ / 20) / t);
  endfunction : tone_half

  // ----------------------------------------
  // link sampling
  // ----------------------------------------
  logic scl_s1_q, scl_s2_q, scl_s3_q;
  logic sda_s1_q, sda_s2_q, sda_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {link.scl, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {link.sda, sda_s1_q, sda_s2_q};
    end
  end
  logic scl_rise, scl_fall, start_seen, stop_seen;
  assign scl_rise = scl_s2_q & ~scl_s3_q;
  assign scl_fall = ~scl_s2_q & scl_s3_q;
  assign start_seen = scl_s2_q & scl_s3_q & sda_s3_q & ~sda_s2_q; // [RQ23]
  assign stop_seen = scl_s2_q & scl_s3_q & ~sda_s3_q & sda_s2_q; // [RQ23]

  // ----------------------------------------
  // frame receiver
  // ----------------------------------------
  mafe_dev_e state_q;
  logic [7:0] shift_q;
  logic [2:0] bit_q;
  logic [1:0] wbyte_q;
  logic [6:0] rbit_q;
  logic [79:0] rframe_q;
  logic [7:0] rx_byte;
  logic byte_done, id_ok, id_read;
  assign rx_byte = {shift_q[6:0], sda_s2_q}; // [RQ24]
  assign byte_done = scl_rise && (bit_q == 3'h7);
  assign id_ok = rx_byte[`MAFE_ID_HDR_MSB:`MAFE_ID_HDR_LSB] == `MAFE_ID_HDR; // [RQ6]
  assign id_read = (state_q == MAFE_DEV_ID) && byte_done && id_ok && rx_byte[`MAFE_ID_RW];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MAFE_DEV_IDLE;
      shift_q <= 8'h00;
      bit_q <= 3'h0;
      wbyte_q <= 2'h0;
    end else if (stop_seen) begin
      state_q <= MAFE_DEV_IDLE; // [RQ13]
    end else if (start_seen) begin
      state_q <= MAFE_DEV_ID; // [RQ7]
      bit_q <= 3'h0;
    end else begin
      case (state_q)
        MAFE_DEV_ID, MAFE_DEV_WR: begin
          if (scl_rise) begin
            shift_q <= rx_byte;
            bit_q <= bit_q + 3'h1;
          end
          if (byte_done && state_q == MAFE_DEV_ID) begin
            wbyte_q <= 2'h0;
            if (!id_ok) begin
              state_q <= MAFE_DEV_IDLE;
            end else if (rx_byte[`MAFE_ID_RW]) begin
              state_q <= MAFE_DEV_RD; // [RQ5]
            end else begin
              state_q <= MAFE_DEV_WR; // [RQ4] [RQ7]
            end
          end
          if (byte_done && state_q == MAFE_DEV_WR) begin
            wbyte_q <= wbyte_q + 2'h1;
            // extra bytes beyond the fourth are ignored
            if (wbyte_q == 2'(`MAFE_WR_BYTES - 1)) begin
              state_q <= MAFE_DEV_IDLE; // [RQ4]
            end
          end
        end
        MAFE_DEV_RD: state_q <= MAFE_DEV_RD;
        MAFE_DEV_IDLE: state_q <= MAFE_DEV_IDLE;
        default: state_q <= MAFE_DEV_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // command bytes and beeper bit
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_function_range <= 8'h00;
      cmd_tone_rate_freq <= 8'h00;
      cmd_ac_filter_opts <= 8'h00;
      cmd_inrush_amp_adapter <= 8'h00;
      beeper_on <= 1'b0;
    end else begin
      if (state_q == MAFE_DEV_ID && byte_done && id_ok) begin
        beeper_on <= rx_byte[`MAFE_ID_BEEP]; // [RQ6] [RQ13]
      end
      if (state_q == MAFE_DEV_WR && byte_done) begin
        case (wbyte_q)
          2'h0: cmd_function_range <= rx_byte; // [RQ8] [RQ19]
          2'h1: cmd_tone_rate_freq <= rx_byte; // [RQ9]
          2'h2: cmd_ac_filter_opts <= {rx_byte[7], 2'h0, rx_byte[4:0]}; // [RQ10]
          default: cmd_inrush_amp_adapter <= {3'h0, rx_byte[4], 1'b0, rx_byte[2:0]}; // [RQ11]
        endcase
      end
    end
  end

  // ----------------------------------------
  // read frame: snapshot and shift out
  // ----------------------------------------
  logic [3:0] fn;
  logic has_fast, has_aux, has_freq;
  logic [79:0] snap;
  logic [18:0] fast_rev;
  assign fn = cmd_function_range[6:3];
  assign fast_rev = bit_rev({9'h000, fast_result});
  // each mode only fills its own result words, the rest read zero
  assign has_fast = (fn != `MAFE_FN_FREQ) && (fn != `MAFE_FN_CAP); // [RQ19]
  assign has_aux = fn == `MAFE_FN_FREQ; // [RQ19]
  assign has_freq = fn == 4'h1 || fn == 4'h3 || fn == `MAFE_FN_FREQ || fn == 4'hA; // [RQ19]
  assign snap = {slow_result_negative, fast_result_negative, 2'h0, // [RQ15] [RQ17]
                 battery_level_flags[0], battery_level_flags[1], divider_flag_lo,
                 alarm_flag, // [RQ20]
                 high_freq_flag, low_freq_flag, low_duty_flag, divider_flag_hi, // [RQ22]
                 cycle_done_flag, // [RQ21]
                 bit_rev(slow_result), // [RQ16]
                 has_fast ? fast_rev[18:9] : 10'h000,
                 has_aux ? bit_rev(aux_result) : 19'h00000,
                 has_freq ? bit_rev(freq_result) : 19'h00000};

  logic sda_oe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rframe_q <= '0;
      rbit_q <= 7'h00;
      sda_oe_q <= 1'b0;
    end else if (id_read) begin
      rframe_q <= snap;
      rbit_q <= 7'h00;
    end else if (state_q != MAFE_DEV_RD) begin
      sda_oe_q <= 1'b0;
    end else if (scl_fall) begin
      // bit leaves on the clock fall so it is stable while clock is high
      if (rbit_q < 7'(`MAFE_RD_BITS)) begin
        sda_oe_q <= ~rframe_q[79]; // [RQ1] [RQ24]
        rframe_q <= {rframe_q[78:0], 1'b0};
        rbit_q <= rbit_q + 7'h01;
      end else begin
        sda_oe_q <= 1'b0;
      end
    end
  end
  assign link.sda_dev_oe = sda_oe_q; // [RQ1]
  assign link.sda_dev_out = 1'b0;

  // ----------------------------------------
  // result-ready
  // ----------------------------------------
  logic data_new_q, conv_event;
  // frequency and capacitance modes wait for the slow result
  assign conv_event = (has_fast && fn != 4'h1 && fn != 4'h3 && fn != 4'hA) ? fast_done
                    : (has_fast ? fast_done : slow_done); // [RQ18]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_new_q <= 1'b0;
    end else if (conv_event) begin
      data_new_q <= 1'b1; // [RQ2]
    end else if (id_read) begin
      data_new_q <= 1'b0; // [RQ3]
    end
  end
  assign link.data_new = data_new_q; // [RQ1]

  // ----------------------------------------
  // conversion timing
  // ----------------------------------------
  logic [1:0] rate;
  logic [22:0] conv_cnt_q, conv_len;
  logic [3:0] fast_n_q;
  assign rate = {cmd_tone_rate_freq[3], cmd_tone_rate_freq[4]}; // [RQ9]
  always_comb begin
    case (rate)
      2'h0: conv_len = 23'(`MAFE_FAST_MS_0 * MS_CYCLES); // [RQ14]
      2'h1: conv_len = 23'(`MAFE_FAST_MS_1 * MS_CYCLES);
      2'h2: conv_len = 23'(`MAFE_FAST_MS_2 * MS_CYCLES);
      default: conv_len = 23'(`MAFE_FAST_MS_3 * MS_CYCLES);
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_q <= 23'h000000;
      fast_n_q <= 4'h0;
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
    end else begin
      fast_tick <= 1'b0;
      slow_tick <= 1'b0;
      if (conv_cnt_q >= conv_len - 23'h000001) begin
        conv_cnt_q <= 23'h000000;
        fast_tick <= 1'b1;
        // one slow conversion spans ten fast ones
        if (fast_n_q == 4'(`MAFE_SLOW_PER_FAST - 1)) begin
          fast_n_q <= 4'h0;
          slow_tick <= 1'b1; // [RQ14]
        end else begin
          fast_n_q <= fast_n_q + 4'h1;
        end
      end else begin
        conv_cnt_q <= conv_cnt_q + 23'h000001;
      end
    end
  end

  // ----------------------------------------
  // beeper tone
  // ----------------------------------------
  logic [2:0] tone;
  logic [16:0] tone_cnt_q;
  assign tone = {cmd_tone_rate_freq[5], cmd_tone_rate_freq[6], cmd_tone_rate_freq[7]}; // [RQ9]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_cnt_q <= 17'h00000;
      beeper_drive_out <= 1'b0;
    end else if (!beeper_on) begin
      tone_cnt_q <= 17'h00000;
      beeper_drive_out <= 1'b0; // [RQ13]
    end else if (tone_cnt_q >= tone_half(tone) - 17'h00001) begin
      tone_cnt_q <= 17'h00000;
      beeper_drive_out <= ~beeper_drive_out; // [RQ12]
    end else begin
      tone_cnt_q <= tone_cnt_q + 17'h00001;
    end
  end
endmodule : mafe_device

// >>> pkg/mafe_map.svh
// constants for the meter front end serial port
// Notes on behaviour
// RQ1 - data open-drain two-way; clock, ready one-way
// RQ2 - ready rises at conversion end, held
// RQ3 - read ID accepted drops ready till next
// RQ4 - write frame: ID then four command bytes
// RQ5 - read frame: ID then ten data bytes
// RQ6 - ID: header, beeper bit, direction bit
// RQ7 - valid write ID always starts write
// RQ8 - first command byte: aux, function, range
// RQ9 - second byte: tone, rate, frequency range
// RQ10 - third byte: AC, diode, adapter, filter, option
// RQ11 - fourth byte: inrush, amplifier, adapter mode
// RQ12 - eight tone codes give eight beeper pitches
// RQ13 - beeper bit alone via ID then stop
// RQ14 - rate code sets slow and fast times
// RQ15 - first two read bytes carry flags
// RQ16 - four binary results packed across bytes
// RQ17 - sign bits mark negative results
// RQ18 - ready per fast conversion, else slow
// RQ19 - function code selects mode and results
// RQ20 - alarm flag reflects device alarm condition
// RQ21 - cycle-done flag marks finished cycle
// RQ22 - frequency and divider flags reported
// RQ23 - start and stop frame every transfer
// RQ24 - bytes msb first, data stable clock high
`ifndef MAFE_MAP_SVH
`define MAFE_MAP_SVH
// ----------------------------------------
// frame layout
// ----------------------------------------
`define MAFE_ID_HDR 6'h32
`define MAFE_ID_HDR_MSB 7
`define MAFE_ID_HDR_LSB 2
`define MAFE_ID_BEEP 1
`define MAFE_ID_RW 0
`define MAFE_WR_BYTES 4
`define MAFE_RD_BITS 80
`define MAFE_FN_FREQ 4'h7
`define MAFE_FN_CAP 4'h8
// ----------------------------------------
// timing
// ----------------------------------------
`define MAFE_PCLK_HZ 125000000
`define MAFE_MS_CYCLES 125000
`define MAFE_SLOW_PER_FAST 10
`define MAFE_FAST_MS_0 50
`define MAFE_FAST_MS_1 30
`define MAFE_FAST_MS_2 25
`define MAFE_FAST_MS_3 20
// beeper pitches in units of 10 Hz
`define MAFE_TONE_0 100
`define MAFE_TONE_1 133
`define MAFE_TONE_2 200
`define MAFE_TONE_3 222
`define MAFE_TONE_4 267
`define MAFE_TONE_5 308
`define MAFE_TONE_6 333
`define MAFE_TONE_7 400
`define MAFE_SCL_QUARTER 313
// ----------------------------------------
// host registers
// ----------------------------------------
`define MAFE_REG_CTRL 8'h00
`define MAFE_REG_CMD 8'h04
`define MAFE_REG_RD0 8'h08
`define MAFE_REG_RD1 8'h0C
`define MAFE_REG_RD2 8'h10
`define MAFE_CTRL_GO 0
`define MAFE_CTRL_KIND_LSB 1
`define MAFE_CTRL_BEEP 3
`define MAFE_STAT_BUSY 0
`define MAFE_STAT_READY 1
`endif

// >>> pkg/mafe_pkg.sv
// types for the meter front end serial port
package mafe_pkg;
  typedef enum logic [3:0] {
    MAFE_DEV_IDLE = 4'b0001,
    MAFE_DEV_ID = 4'b0010,
    MAFE_DEV_WR = 4'b0100,
    MAFE_DEV_RD = 4'b1000
  } mafe_dev_e;
  typedef enum logic [3:0] {
    MAFE_HST_IDLE = 4'b0001,
    MAFE_HST_START = 4'b0010,
    MAFE_HST_BITS = 4'b0100,
    MAFE_HST_STOP = 4'b1000
  } mafe_hst_e;
  typedef enum logic [1:0] {
    MAFE_KIND_BEEP = 2'h0,
    MAFE_KIND_WRITE = 2'h1,
    MAFE_KIND_READ = 2'h2
  } mafe_kind_e;
endpackage : mafe_pkg

// >>> pkg/mafe_link_if.sv
// three-wire link between host and front end
interface mafe_link_if;
  logic scl;
  logic sda_host_out;
  logic sda_host_oe;
  logic sda_dev_out;
  logic sda_dev_oe;
  logic data_new;
  logic sda;
  // open-drain wire: any driver pulls, idle floats high
  assign sda = (sda_host_oe ? sda_host_out : 1'b1) & (sda_dev_oe ? sda_dev_out : 1'b1);
  modport device(input scl, input sda, output sda_dev_out, output sda_dev_oe, output data_new);
  modport host(output scl, output sda_host_out, output sda_host_oe, input sda, input data_new);
endinterface : mafe_link_if

// >>> hw/mafe_host.sv
// host end of the serial port: apb registers and frame sequencer
`include "mafe_map.svh"
module mafe_host import mafe_pkg::*; #(
  parameter int QUARTER = `MAFE_SCL_QUARTER
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  mafe_link_if.host link
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] cmd_q;
  logic [79:0] rx_q;
  logic beep_q, busy_q, go;
  mafe_kind_e kind_q;
  logic dn_s1_q, dn_s2_q, sda_s1_q, sda_s2_q;
  logic acc;
  assign acc = psel & penable & pready;
  assign go = acc && pwrite && paddr == `MAFE_REG_CTRL && pwdata[`MAFE_CTRL_GO] && !busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // ready idles low, data line idles high
      {dn_s1_q, dn_s2_q, sda_s1_q, sda_s2_q} <= 4'h3;
    end else begin
      {dn_s1_q, dn_s2_q} <= {link.data_new, dn_s1_q};
      {sda_s1_q, sda_s2_q} <= {link.sda, sda_s1_q};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & ~penable & ~pready;
      pslverr <= psel & ~penable & ~pready & !(paddr inside {`MAFE_REG_CTRL,
                 `MAFE_REG_CMD, `MAFE_REG_RD0, `MAFE_REG_RD1, `MAFE_REG_RD2});
      case (paddr)
        `MAFE_REG_CTRL: prdata <= {28'h0000000, beep_q, 1'b0, dn_s2_q, busy_q};
        `MAFE_REG_CMD: prdata <= cmd_q;
        `MAFE_REG_RD0: prdata <= rx_q[79:48];
        `MAFE_REG_RD1: prdata <= rx_q[47:16];
        `MAFE_REG_RD2: prdata <= {16'h0000, rx_q[15:0]};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q <= 32'h00000000;
      beep_q <= 1'b0;
      kind_q <= MAFE_KIND_BEEP;
    end else if (acc && pwrite && paddr == `MAFE_REG_CMD && !busy_q) begin
      cmd_q <= pwdata; // [RQ4]
    end else if (go) begin
      beep_q <= pwdata[`MAFE_CTRL_BEEP];
      kind_q <= mafe_kind_e'(pwdata[`MAFE_CTRL_KIND_LSB +: 2]);
    end
  end

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  mafe_hst_e st_q;
  logic [15:0] qcnt_q;
  logic [1:0] ph_q;
  logic [6:0] nbit_q, total;
  logic [39:0] tx_q;
  logic scl_q, oe_q, tick;
  assign tick = qcnt_q == 16'(QUARTER - 1);
  // beeper-only frame is the ID byte followed by stop
  assign total = kind_q == MAFE_KIND_READ ? 7'd88
               : (kind_q == MAFE_KIND_WRITE ? 7'd40 : 7'd8); // [RQ4] [RQ5] [RQ13]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= MAFE_HST_IDLE;
      qcnt_q <= 16'h0000;
      ph_q <= 2'h0;
      nbit_q <= 7'h00;
      tx_q <= 40'h0000000000;
      rx_q <= 80'h0;
      scl_q <= 1'b1;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
    end else if (st_q == MAFE_HST_IDLE) begin
      qcnt_q <= 16'h0000;
      ph_q <= 2'h0;
      if (go) begin
        st_q <= MAFE_HST_START;
        busy_q <= 1'b1;
        nbit_q <= 7'h00;
        tx_q <= {`MAFE_ID_HDR, pwdata[`MAFE_CTRL_BEEP], pwdata[`MAFE_CTRL_KIND_LSB + 1],
                 cmd_q}; // [RQ6]
      end
    end else if (!tick) begin
      qcnt_q <= qcnt_q + 16'h0001;
    end else begin
      qcnt_q <= 16'h0000;
      ph_q <= ph_q + 2'h1;
      case (st_q)
        MAFE_HST_START: begin
          case (ph_q)
            2'h1: oe_q <= 1'b1; // [RQ23]
            2'h2: scl_q <= 1'b0;
            2'h3: st_q <= MAFE_HST_BITS;
            default: oe_q <= 1'b0;
          endcase
        end
        MAFE_HST_BITS: begin
          case (ph_q)
            // data changes only while clock is low
            // a read hands the line to the front end after the id byte
            2'h0: oe_q <= (nbit_q < 7'd8 || (kind_q == MAFE_KIND_WRITE && nbit_q < 7'd40))
                          ? ~tx_q[39] : 1'b0; // [RQ24] [RQ1] [RQ5]
            2'h1: scl_q <= 1'b1;
            2'h2: begin
              if (nbit_q >= 7'd8 && kind_q == MAFE_KIND_READ) begin
                rx_q <= {rx_q[78:0], sda_s2_q}; // [RQ5]
              end
            end
            default: begin
              scl_q <= 1'b0;
              tx_q <= {tx_q[38:0], 1'b0};
              nbit_q <= nbit_q + 7'h01;
              if (nbit_q == total - 7'h01) begin
                st_q <= MAFE_HST_STOP;
              end
            end
          endcase
        end
        MAFE_HST_STOP: begin
          case (ph_q)
            2'h0: oe_q <= 1'b1;
            2'h1: scl_q <= 1'b1;
            2'h2: oe_q <= 1'b0; // [RQ23]
            default: begin
              st_q <= MAFE_HST_IDLE;
              busy_q <= 1'b0;
            end
          endcase
        end
        default: st_q <= MAFE_HST_IDLE;
      endcase
    end
  end
  assign link.scl = scl_q; // [RQ1]
  assign link.sda_host_oe = oe_q;
  assign link.sda_host_out = 1'b0;
endmodule : mafe_host

// >>> bench/mafe_link_chk.sv
// checker for the three-wire link between host and front end
module mafe_link_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scl,
  input wire logic sda_host_out,
  input wire logic sda_host_oe,
  input wire logic sda_dev_out,
  input wire logic sda_dev_oe,
  input wire logic data_new,
  input wire logic sda
);
  logic scl_q;
  logic [3:0] rise_age_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // helper: cycles since the last scl rise
  // ----------------------------------------
  // saturates so a long idle bus cannot wrap back into the window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      rise_age_q <= 4'hF;
    end else begin
      scl_q <= scl;
      if (scl && !scl_q) begin
        rise_age_q <= 4'h0;
      end else if (rise_age_q != 4'hF) begin
        rise_age_q <= rise_age_q + 4'h1;
      end
    end
  end
  // ----------------------------------------
  // link rules
  // ----------------------------------------
  sequence s_start;
    $fell(sda) && scl;
  endsequence
  sequence s_stop;
    $rose(sda) && scl;
  endsequence
  AST_HOST_OD: assert property (sda_host_oe |-> !sda_host_out)
    else $error("host drives the data line high");
  AST_DEV_OD: assert property (sda_dev_oe |-> !sda_dev_out)
    else $error("device drives the data line high");
  AST_DEV_EDGE: assert property ($changed(sda_dev_oe) |-> !scl)
    else $error("device changed data while clock high");
  AST_START_HOLD: assert property (s_start |=> scl [*3])
    else $error("clock fell too soon after start");
  AST_STOP_IDLE: assert property (s_stop |=> scl [*4])
    else $error("clock moved right after stop");
  AST_BIT_STABLE: assert property ($rose(scl) |-> $stable(sda) [*3])
    else $error("data moved while clock high");
  AST_LOW_LEN: assert property ($fell(scl) |-> !scl [*4])
    else $error("clock low phase too short");
  AST_READY_DROP: assert property ($fell(data_new) |-> rise_age_q inside {[2:6]})
    else $error("ready fell away from an id bit");
endmodule : mafe_link_chk

// >>> bench/meter_afe_serial_port_bench.sv
// bench: host and front end joined by the link, driven over apb
`include "mafe_map.svh"
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
  end \
end
module meter_afe_serial_port_bench import mafe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // short counts keep the run brief
  localparam int MS = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, beep, fast_tick, slow_tick, tone_out;
  logic fast_done = 1'b0, slow_done = 1'b0, sneg = 1'b0, fneg = 1'b0, dlo = 1'b0;
  logic dhi = 1'b0, alarm = 1'b0, hf = 1'b0, lf = 1'b0, ldu = 1'b0, cyc = 1'b0;
  logic [1:0] bat = 2'h0;
  logic [18:0] slow_r = 19'h0, aux_r = 19'h0, freq_r = 19'h0;
  logic [9:0] fast_r = 10'h0;
  logic [7:0] w1, w2, w3, w4;
  int n_fail = 0;
  int cmp_count = 0;
  always #4 pclk = ~pclk;
  mafe_link_if link();
  mafe_host #(.QUARTER(4)) mafe_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  mafe_device #(.MS_CYCLES(MS)) mafe_device_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .fast_done(fast_done), .slow_done(slow_done), .slow_result_negative(sneg),
    .fast_result_negative(fneg), .battery_level_flags(bat), .divider_flag_lo(dlo),
    .divider_flag_hi(dhi), .alarm_flag(alarm), .high_freq_flag(hf), .low_freq_flag(lf),
    .low_duty_flag(ldu), .cycle_done_flag(cyc), .slow_result(slow_r), .fast_result(fast_r),
    .aux_result(aux_r), .freq_result(freq_r), .cmd_function_range(w1),
    .cmd_tone_rate_freq(w2), .cmd_ac_filter_opts(w3), .cmd_inrush_amp_adapter(w4),
    .beeper_on(beep), .beeper_drive_out(tone_out), .fast_tick(fast_tick),
    .slow_tick(slow_tick));
  mafe_link_chk mafe_link_chk_inst (.pclk(pclk), .presetn(presetn), .scl(link.scl),
    .sda_host_out(link.sda_host_out), .sda_host_oe(link.sda_host_oe),
    .sda_dev_out(link.sda_dev_out), .sda_dev_oe(link.sda_dev_oe),
    .data_new(link.data_new), .sda(link.sda));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave asks; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd
  task automatic go(input mafe_kind_e k, input logic b);
    logic [31:0] q;
    logic e;
    int n;
    apb(1'b1, `MAFE_REG_CTRL, {28'h0, b, k, 1'b1}, q, e);
    // poll rather than assume the frame length
    for (n = 0; n < 2000 && (n == 0 || q[`MAFE_STAT_BUSY] !== 1'b0); n++) rd(`MAFE_REG_CTRL, q);
    `CHK(q[`MAFE_STAT_BUSY], 1'b0)
  endtask : go
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write();
    logic [31:0] q;
    logic e;
    apb(1'b1, `MAFE_REG_CMD, 32'hA55AFFFF, q, e);
    go(MAFE_KIND_WRITE, 1'b1);
    `CHK(w1, 8'hA5)
    `CHK(w2, 8'h5A)
    `CHK(w3, 8'h9F)
    `CHK(w4, 8'h17)
    `CHK(beep, 1'b1)
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    logic [79:0] x;
    logic [31:0] q;
    int n;
    @(posedge pclk);
    {sneg, alarm, bat, hf, ldu, cyc, fast_done} <= 8'hFF;
    slow_r <= 19'h5A3C1;
    fast_r <= 10'h2B7;
    aux_r <= 19'h12345;
    freq_r <= 19'h6789A;
    @(posedge pclk);
    fast_done <= 1'b0;
    for (n = 0; n < 10 && link.data_new !== 1'b1; n++) @(posedge pclk);
    repeat (6) @(posedge pclk);
    `CHK(link.data_new, 1'b1)
    rd(`MAFE_REG_CTRL, q);
    `CHK(q[`MAFE_STAT_READY], 1'b1)
    go(MAFE_KIND_READ, 1'b1);
    `CHK(link.data_new, 1'b0)
    // resistance mode: aux and frequency words stay zero
    x = {8'h8D, 5'b10101, 67'h0};
    for (int i = 0; i < 19; i++) x[66 - i] = slow_r[i];
    for (int i = 0; i < 10; i++) x[47 - i] = fast_r[i];
    rd(`MAFE_REG_RD0, q);
    `CHK(q, x[79:48])
    rd(`MAFE_REG_RD1, q);
    `CHK(q, x[47:16])
    rd(`MAFE_REG_RD2, q);
    `CHK(q, {16'h0, x[15:0]})
    $display("test read done");
  endtask : t_read
  task automatic t_tone();
    logic [31:0] q;
    logic e;
    int n;
    // top tone code, rate code kept at the fastest setting
    apb(1'b1, `MAFE_REG_CMD, 32'hA5F8FFFF, q, e);
    go(MAFE_KIND_WRITE, 1'b1);
    @(posedge tone_out);
    @(posedge pclk);
    for (n = 0; tone_out === 1'b1; n++) @(posedge pclk);
    `CHK(n, (`MAFE_PCLK_HZ / 2) / 4000)
    $display("test tone done");
  endtask : t_tone
  task automatic t_beep();
    logic [31:0] q;
    logic e;
    go(MAFE_KIND_BEEP, 1'b0);
    `CHK(beep, 1'b0)
    `CHK(tone_out, 1'b0)
    `CHK(w1, 8'hA5)
    apb(1'b0, 8'h20, 32'h0, q, e);
    `CHK(e, 1'b1)
    $display("test beep done");
  endtask : t_beep
  task automatic gap(input logic s, output int n);
    for (n = 0; n < 3000 && (s ? slow_tick : fast_tick) !== 1'b1; n++) @(posedge pclk);
    @(posedge pclk);
    for (n = 1; n < 3000 && (s ? slow_tick : fast_tick) !== 1'b1; n++) @(posedge pclk);
  endtask : gap
  task automatic t_rate();
    int n;
    gap(1'b0, n);
    `CHK(n, 20 * MS)
    gap(1'b1, n);
    `CHK(n, 200 * MS)
    $display("test rate done");
  endtask : t_rate
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_write();
    t_read();
    t_tone();
    t_beep();
    t_rate();
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge pclk);
    n_fail++;
    finish_test();
  end
endmodule : meter_afe_serial_port_bench
